// ===== rtl/ctmw_top.v
// transceiver mode control and standard wake-up detector with apb registers
`timescale 1ns/10ps
`include "ctmw_map.vh"

// Function
// - standby or sleep hold transceiver offline or offline bias by bus activity
// - select 01 or 10 requests active: tx drives bus, rx follows bus
// - select 01: supply undervoltage drops active to offline or offline bias
// - select 10: ignore undervoltage, leave active only when device sleeps
// - active needs normal mode, select 01/10, supply good when 01
// - tx input low on active select gives listen-only until tx high
// - readable status bit shows transceiver is in active mode
// - normal with select 11 is listen-only: transmitter off, receiver on
// - stay listen-only while tx low or active selected under undervoltage
// - offline monitors wake only with wake enable; bus biased to ground
// - offline moves to bias on activity, back after silence timeout
// - leaving active/listen goes offline if silent, else via offline bias
// - off or overtemp to standby enters offline
// - offline to bias on wake pattern or normal active select under 90 percent
// - off or overtemp or low battery float bus; restart offline on recovery
// - standard wake monitoring needs offline, wake enable, no selective wake; here it also runs in offline bias, and with selective wake if config invalid
// - wake pattern is dominant, recessive, dominant with minimum phase times
// - shorter intervals between phases are ignored by the detector
// - pattern must complete within timeout else detector restarts
// - rx high until wake; valid pattern sets wake flag and drives rx low
// - wake while in sleep raises inhibit output and enters standby
// - select field: 00 offline, 01 active uv, 10 active no uv, 11 listen
// - device mode field: 001 sleep, 100 standby, 111 normal
module ctmw_top #(
   parameter SILENCE_CYC = `CTMW_SILENCE_CYC,
   parameter DOM_CYC     = `CTMW_DOM_CYC,
   parameter REC_CYC     = `CTMW_REC_CYC,
   parameter WAKE_TO_CYC = `CTMW_WAKE_TO_CYC
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // protocol controller side
   input  wire        txd_i,
   output reg         rxd_o,
   // bus side, digital view of the analog front end
   input  wire        bus_dominant_i,
   output reg         bus_drive_dom_o,
   output reg         bus_tx_en_o,
   output reg         bus_bias_mid_o,
   output reg         bus_bias_gnd_o,
   output reg         bus_float_o,
   // supply and device state
   input  wire        vcc_uv_i,
   input  wire        vcc_low90_i,
   input  wire        vbat_uv_i,
   input  wire        dev_off_i,
   input  wire        dev_overtemp_i,
   input  wire        sleep_by_uv_i,
   output reg         regulator_inhibit_out_o,
   output reg         xcvr_active_o
);

   // counter width holds the default timeouts at 20 MHz with margin;
   // counters saturate, and a parameter above 2^CW - 1 is cut to its low CW bits
   localparam CW = 21;

   // every pin-side input is asynchronous to clk_i; logic below reads
   // only the second stage, the first is left to settle metastability
   // synchronised pins
   reg [1:0] txd_s_r, dom_s_r, vuv_s_r, v90_s_r, vbat_s_r, off_s_r, ot_s_r, suv_s_r;
   wire txd_q  = txd_s_r[1];
   wire dom_q  = dom_s_r[1];
   wire vuv_q  = vuv_s_r[1];
   wire v90_q  = v90_s_r[1];
   wire vbat_q = vbat_s_r[1];
   wire off_q  = off_s_r[1] | ot_s_r[1];
   wire suv_q  = suv_s_r[1];

   // control fields
   reg  [31:0] ctrl_r;
   wire [1:0]  xcvr_mode_select   = ctrl_r[`CTMW_XCVR_LSB +: 2];
   wire [2:0]  device_mode_select = ctrl_r[`CTMW_DEVM_LSB +: 3];
   wire        can_wake_enable          = ctrl_r[`CTMW_WAKE_EN_BIT];
   wire        selective_wake_enable    = ctrl_r[`CTMW_SEL_WAKE_BIT];
   wire        partial_net_config_valid = ctrl_r[`CTMW_PN_VALID_BIT];

   // state, wake detector and timer registers
   reg [2:0]    st_r, st_nxt;
   reg          can_wake_event_flag_r;
   reg          wake_pend_r;
   reg          dom_d_r;
   reg          off_d_r;
   reg [CW-1:0] sil_cnt_r;
   reg [1:0]    wph_r;
   reg [CW-1:0] ph_cnt_r;
   reg [CW-1:0] wto_cnt_r;
   reg          wake_hit;

   // wake detector phases
   localparam WP_IDLE = 2'h0;
   localparam WP_DOM1 = 2'h1;
   localparam WP_REC  = 2'h2;
   localparam WP_DOM2 = 2'h3;

   // saturating increment shared by all phase and timeout counters
   function [CW-1:0] sat_inc;
      input [CW-1:0] v;
      begin
         sat_inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
      end
   endfunction

   wire edge_seen = dom_q ^ dom_d_r;
   wire silent    = (sil_cnt_r >= SILENCE_CYC[CW-1:0]);
   // a forced undervoltage sleep overrides the software mode, so the
   // transceiver must not re-enter active while sleep_by_uv_i stands
   wire dev_norm  = (device_mode_select == `CTMW_DM_NORMAL) & ~suv_q;
   wire act_sel   = (xcvr_mode_select == `CTMW_XS_ACT_UV) |
                    (xcvr_mode_select == `CTMW_XS_ACT_NOUV);
   wire uv_block  = (xcvr_mode_select == `CTMW_XS_ACT_UV) & vuv_q;
   // offline bias only differs from offline in its bias level, and the
   // first dominant edge of a pattern already moves offline to bias
   wire mon_en    = ((st_r == `CTMW_ST_OFFLINE) | (st_r == `CTMW_ST_OFFBIAS)) &
                    can_wake_enable &
                    (~selective_wake_enable | ~partial_net_config_valid);
   wire can_off   = off_q | vbat_q;
   // reads are looked up on the first access edge; writes land on the edge
   // at which the master sees ready, so an aborted access changes nothing
   wire apb_acc   = psel_i & penable_i & ~pready_o;
   wire apb_wr    = psel_i & penable_i & pready_o & pwrite_i;

   // input synchronisers, first stage read only by the second
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         txd_s_r  <= 2'h3;
         dom_s_r  <= 2'h0;
         vuv_s_r  <= 2'h0;
         v90_s_r  <= 2'h0;
         vbat_s_r <= 2'h0;
         off_s_r  <= 2'h0;
         ot_s_r   <= 2'h0;
         suv_s_r  <= 2'h0;
      end else begin
         txd_s_r  <= {txd_s_r[0], txd_i};
         dom_s_r  <= {dom_s_r[0], bus_dominant_i};
         vuv_s_r  <= {vuv_s_r[0], vcc_uv_i};
         v90_s_r  <= {v90_s_r[0], vcc_low90_i};
         vbat_s_r <= {vbat_s_r[0], vbat_uv_i};
         off_s_r  <= {off_s_r[0], dev_off_i};
         ot_s_r   <= {ot_s_r[0], dev_overtemp_i};
         suv_s_r  <= {suv_s_r[0], sleep_by_uv_i};
      end
   end

   // silence is measured on the synchronised receiver output, so a
   // spike shorter than a clock period may be missed; the analog filter
   // in front is expected to remove those anyway
   // bus silence timer, restarts on any edge
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         dom_d_r   <= 1'b0;
         sil_cnt_r <= {CW{1'b0}};
      end else begin
         dom_d_r   <= dom_q;
         sil_cnt_r <= edge_seen ? {CW{1'b0}} : sat_inc(sil_cnt_r);
      end
   end

   // next-state logic for the five transceiver states; off has the final
   // word below because a lost battery or hot die must float the bus
   // whatever the software asked for. entry into active checks txd here
   // so a controller stuck dominant cannot take the bus
   // transceiver mode selection
   always @* begin
      st_nxt = st_r;
      case (st_r)
         `CTMW_ST_OFF: begin
            // leave off only once every reason for it has cleared
            if (!can_off)
               st_nxt = `CTMW_ST_OFFLINE;
         end
         `CTMW_ST_OFFLINE: begin
            if (dev_norm && act_sel && !uv_block && !v90_q)
               st_nxt = txd_q ? `CTMW_ST_ACTIVE : `CTMW_ST_LISTEN;
            else if (dev_norm && xcvr_mode_select == `CTMW_XS_LISTEN)
               st_nxt = `CTMW_ST_LISTEN;
            else if (edge_seen || wake_hit || (dev_norm && act_sel && v90_q))
               st_nxt = `CTMW_ST_OFFBIAS;
         end
         `CTMW_ST_OFFBIAS: begin
            if (dev_norm && act_sel && !uv_block)
               st_nxt = txd_q ? `CTMW_ST_ACTIVE : `CTMW_ST_LISTEN;
            else if (dev_norm && xcvr_mode_select == `CTMW_XS_LISTEN)
               st_nxt = `CTMW_ST_LISTEN;
            // back to ground bias only after a full silence window
            else if (silent)
               st_nxt = `CTMW_ST_OFFLINE;
         end
         `CTMW_ST_ACTIVE: begin
            // select 10 keeps transmitting through undervoltage until forced sleep
            if (!dev_norm || xcvr_mode_select == `CTMW_XS_OFFLINE || uv_block ||
                (xcvr_mode_select == `CTMW_XS_ACT_NOUV && suv_q))
               st_nxt = silent ? `CTMW_ST_OFFLINE : `CTMW_ST_OFFBIAS;
            else if (xcvr_mode_select == `CTMW_XS_LISTEN)
               st_nxt = `CTMW_ST_LISTEN;
            // a dominant txd while active is ordinary traffic; the stuck-low
            // guard only applies on the way in, from offline, bias or listen
         end
         `CTMW_ST_LISTEN: begin
            if (!dev_norm || xcvr_mode_select == `CTMW_XS_OFFLINE)
               st_nxt = silent ? `CTMW_ST_OFFLINE : `CTMW_ST_OFFBIAS;
            else if (act_sel && txd_q && !uv_block)
               st_nxt = `CTMW_ST_ACTIVE;
         end
         default: st_nxt = `CTMW_ST_OFFLINE;
      endcase
      if (can_off)
         st_nxt = `CTMW_ST_OFF;
   end

   // state register; starts off, but leaves it on the first clock after reset
   // because the synchronisers reset to supplies good, before any pin is seen

   always @(posedge clk_i) begin
      if (!rst_n_i)
         st_r <= `CTMW_ST_OFF;
      else
         st_r <= st_nxt;
   end

   // the detector runs in offline and offline bias alike; an offline-only
   // detector could never see a whole pattern. the timeout counts from
   // the first dominant sample and, once reached, clears every phase
   // so the whole pattern has to be sent again
   // wake pattern detector: short glitches hold the phase timer, except in the first dominant phase, which restarts
   always @* begin
      wake_hit = mon_en && wph_r == WP_DOM2 && dom_q &&
                 ph_cnt_r >= DOM_CYC[CW-1:0] - 1'b1 &&
                 wto_cnt_r < WAKE_TO_CYC[CW-1:0];
   end

   always @(posedge clk_i) begin
      if (!rst_n_i || !mon_en || wake_hit || wto_cnt_r >= WAKE_TO_CYC[CW-1:0]) begin
         wph_r     <= WP_IDLE;
         ph_cnt_r  <= {CW{1'b0}};
         wto_cnt_r <= {CW{1'b0}};
      end else begin
         wto_cnt_r <= (wph_r == WP_IDLE) ? {CW{1'b0}} : sat_inc(wto_cnt_r);
         case (wph_r)
            WP_IDLE: begin
               if (dom_q) begin
                  wph_r    <= WP_DOM1;
                  ph_cnt_r <= {CW{1'b0}};
               end
            end
            WP_DOM1: begin
               if (dom_q)
                  ph_cnt_r <= sat_inc(ph_cnt_r);
               else if (ph_cnt_r >= DOM_CYC[CW-1:0]) begin
                  wph_r    <= WP_REC;
                  ph_cnt_r <= {CW{1'b0}};
               end else
                  wph_r    <= WP_IDLE;
            end
            WP_REC: begin
               if (!dom_q)
                  ph_cnt_r <= sat_inc(ph_cnt_r);
               else if (ph_cnt_r >= REC_CYC[CW-1:0]) begin
                  wph_r    <= WP_DOM2;
                  ph_cnt_r <= {CW{1'b0}};
               end
               // short dominant bits inside the recessive phase are ignored
               else
                  ph_cnt_r <= ph_cnt_r;
            end
            WP_DOM2: begin
               if (dom_q)
                  ph_cnt_r <= sat_inc(ph_cnt_r);
               else
                  ph_cnt_r <= ph_cnt_r;
            end
            default: wph_r <= WP_IDLE;
         endcase
      end
   end

   // software writes win over the hardware mode update in the same cycle;
   // the wake flag stays set, so software can still request standby
   // control register, wake flag and pending wake, sleep to standby on wake
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_r                <= `CTMW_CTRL_RST;
         can_wake_event_flag_r <= 1'b0;
         wake_pend_r           <= 1'b0;
         off_d_r               <= 1'b1;
      end else begin
         off_d_r <= off_q;
         if (apb_wr && paddr_i == `CTMW_CTRL_OFS)
            ctrl_r <= {21'h0, pwdata_i[10:8], 1'b0, pwdata_i[6:4], 2'h0, pwdata_i[1:0]};
         else if (wake_hit && device_mode_select == `CTMW_DM_SLEEP)
            ctrl_r[`CTMW_DEVM_LSB +: 3] <= `CTMW_DM_STANDBY;
         else if (off_d_r && !off_q)
            ctrl_r[`CTMW_DEVM_LSB +: 3] <= `CTMW_DM_STANDBY;
         // set wins over a software write-one clear in the same cycle
         if (wake_hit)
            can_wake_event_flag_r <= 1'b1;
         else if (apb_wr && paddr_i == `CTMW_EVT_OFS && pwdata_i[0])
            can_wake_event_flag_r <= 1'b0;
         // a pending wake holds rxd low until the controller takes the bus
         if (wake_hit)
            wake_pend_r <= 1'b1;
         else if (st_r == `CTMW_ST_ACTIVE || st_r == `CTMW_ST_LISTEN)
            wake_pend_r <= 1'b0;
      end
   end

   // outputs decode the next state, so pins change on the same edge as
   // the state register and no decode glitch reaches the analog drivers
   // registered outputs toward bus, controller and regulator
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rxd_o                   <= 1'b1;
         bus_drive_dom_o         <= 1'b0;
         bus_tx_en_o             <= 1'b0;
         bus_bias_mid_o          <= 1'b0;
         bus_bias_gnd_o          <= 1'b0;
         bus_float_o             <= 1'b1;
         regulator_inhibit_out_o <= 1'b0;
         xcvr_active_o           <= 1'b0;
      end else begin
         bus_tx_en_o     <= (st_nxt == `CTMW_ST_ACTIVE);
         bus_drive_dom_o <= (st_nxt == `CTMW_ST_ACTIVE) & ~txd_q;
         bus_bias_mid_o  <= (st_nxt == `CTMW_ST_ACTIVE) | (st_nxt == `CTMW_ST_LISTEN) |
                            (st_nxt == `CTMW_ST_OFFBIAS);
         bus_bias_gnd_o  <= (st_nxt == `CTMW_ST_OFFLINE);
         bus_float_o     <= (st_nxt == `CTMW_ST_OFF);
         xcvr_active_o   <= (st_nxt == `CTMW_ST_ACTIVE);
         if (st_nxt == `CTMW_ST_ACTIVE || st_nxt == `CTMW_ST_LISTEN)
            rxd_o <= ~dom_q;
         else
            rxd_o <= ~(wake_pend_r | wake_hit);
         regulator_inhibit_out_o <= ~off_q &
                                    (device_mode_select != `CTMW_DM_SLEEP || wake_hit);
      end
   end

   // the wait state keeps every bus output registered; read data is a
   // snapshot taken on the first access edge and shown with ready
   // apb slave: one wait state, unmapped addresses answer with an error
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= apb_acc;
         pslverr_o <= apb_acc & paddr_i != `CTMW_CTRL_OFS & paddr_i != `CTMW_STAT_OFS &
                      paddr_i != `CTMW_EVT_OFS;
         prdata_o  <= 32'h0000_0000;
         if (apb_acc && !pwrite_i) begin
            case (paddr_i)
               `CTMW_CTRL_OFS: prdata_o <= ctrl_r;
               `CTMW_STAT_OFS: prdata_o <= {24'h0, xcvr_active_o, 2'h0, wph_r, st_r};
               `CTMW_EVT_OFS:  prdata_o <= {31'h0, can_wake_event_flag_r};
               default:        prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // ctmw_top

// ===== inc/ctmw_map.vh
// register offsets, field positions, reset values and timing counts for the transceiver mode block
`ifndef CTMW_MAP_VH
`define CTMW_MAP_VH
// register byte offsets
`define CTMW_CTRL_OFS      12'h000
`define CTMW_STAT_OFS      12'h004
`define CTMW_EVT_OFS       12'h008
// control field positions
`define CTMW_XCVR_LSB      0
`define CTMW_DEVM_LSB      4
`define CTMW_WAKE_EN_BIT   8
`define CTMW_SEL_WAKE_BIT  9
`define CTMW_PN_VALID_BIT  10
`define CTMW_CTRL_RST      32'h0000_0040
// transceiver mode select encodings
`define CTMW_XS_OFFLINE    2'h0
`define CTMW_XS_ACT_UV     2'h1
`define CTMW_XS_ACT_NOUV   2'h2
`define CTMW_XS_LISTEN     2'h3
// device mode select encodings
`define CTMW_DM_SLEEP      3'h1
`define CTMW_DM_STANDBY    3'h4
`define CTMW_DM_NORMAL     3'h7
// transceiver state codes
`define CTMW_ST_OFF        3'h0
`define CTMW_ST_OFFLINE    3'h1
`define CTMW_ST_OFFBIAS    3'h2
`define CTMW_ST_ACTIVE     3'h3
`define CTMW_ST_LISTEN     3'h4
// timing in microseconds and cycles at 20 MHz
`define CTMW_CLK_MHZ       20
`define CTMW_SILENCE_US    1000
`define CTMW_DOM_US        5
`define CTMW_REC_US        5
`define CTMW_WAKE_TO_US    1000
`define CTMW_SILENCE_CYC   (`CTMW_SILENCE_US * `CTMW_CLK_MHZ)
`define CTMW_DOM_CYC       (`CTMW_DOM_US * `CTMW_CLK_MHZ)
`define CTMW_REC_CYC       (`CTMW_REC_US * `CTMW_CLK_MHZ)
`define CTMW_WAKE_TO_CYC   (`CTMW_WAKE_TO_US * `CTMW_CLK_MHZ)
`endif

// ===== verif/ctmw_checker.sv
// assertion checker for the transceiver mode control block
`timescale 1ns/10ps
module ctmw_checker (
   // clock, reset and apb handshake
   input wire clk_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pready_o,
   input wire pslverr_o,
   // device state and bus side
   input wire dev_off_i,
   input wire bus_drive_dom_o,
   input wire bus_tx_en_o,
   input wire bus_bias_mid_o,
   input wire bus_bias_gnd_o,
   input wire bus_float_o,
   input wire xcvr_active_o
);
   // one clock domain, so one default clock and reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_drive_needs_tx: assert property (bus_drive_dom_o |-> bus_tx_en_o)
      else $error("dominant drive without transmitter");
   a_status_tracks_tx: assert property (xcvr_active_o == bus_tx_en_o)
      else $error("active status differs from transmitter");
   a_float_alone: assert property (bus_float_o |-> !bus_bias_mid_o && !bus_bias_gnd_o)
      else $error("floating bus still biased");
   a_gnd_no_tx: assert property (bus_bias_gnd_o |-> !bus_tx_en_o && !bus_bias_mid_o)
      else $error("ground bias with transmitter or mid bias");
   a_tx_has_bias: assert property (bus_tx_en_o |-> bus_bias_mid_o)
      else $error("transmitter on without mid bias");
   a_off_floats: assert property (dev_off_i [*6] |-> bus_float_o)
      else $error("device off but bus not floating");
   a_ready_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("ready not one cycle after access");
   a_ready_pulse: assert property (pready_o |=> !pready_o or $fell(psel_i))
      else $error("ready held longer than a cycle");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
endmodule // ctmw_checker

bind ctmw_top ctmw_checker chk_u (.*);

// ===== verif/ctmw_ctl_model.sv
// protocol controller model: sends bytes on txd, checks the echo on rxd
`timescale 1ns/10ps
module ctmw_ctl_model (
   // clock and bench commands
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [7:0] byte_i,
   input  wire logic       hold_low_i,
   // transceiver side
   input  wire logic       rxd_i,
   output logic            txd_o,
   output logic            busy_o,
   output int              bad_o
);
   logic [7:0] sh = 8'hff;
   int         n  = 0;
   initial busy_o = 1'b0;
   initial bad_o = 0;
   // twelve clocks a bit leave room for the synchroniser round trip
   always @(posedge clk_i) begin
      if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         sh     <= byte_i;
         n      <= 0;
      end else if (busy_o) begin
         n <= n + 1;
         if (n % 12 == 11) begin
            if (rxd_i !== sh[7]) bad_o <= bad_o + 1;
            sh     <= {sh[6:0], 1'b1};
            busy_o <= (n != 95);
         end
      end
   end
   // idle line is recessive; stuck low only when the bench asks
   assign txd_o = hold_low_i ? 1'b0 : (busy_o ? sh[7] : 1'b1);
endmodule // ctmw_ctl_model

// ===== verif/can_transceiver_mode_wake_bench.sv
// self-checking bench for transceiver mode control and wake detector
`timescale 1ns/10ps
`include "ctmw_map.vh"
module can_transceiver_mode_wake_bench;
   localparam int DOM = 4;
   localparam int REC = 4;
   localparam int WTO = 200;
   logic        clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, wdom = 0, go = 0, hold = 0;
   logic        vuv = 0, v90 = 0, buv = 0, doff = 0, dot = 0, suv = 0;
   logic        pready, pslverr, er, rxd, txd, drv, txen, bmid, bgnd, bfl, regulator_inhibit_out, act, busy;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata, seed = 32'h31;
   logic [7:0]  byt = 8'h00;
   int          err_count = 0, samples_checked = 0, bad, k;

   ctmw_top #(.SILENCE_CYC(40), .DOM_CYC(DOM), .REC_CYC(REC), .WAKE_TO_CYC(WTO)) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .txd_i(txd), .rxd_o(rxd), .bus_dominant_i(drv | wdom),
      .bus_drive_dom_o(drv), .bus_tx_en_o(txen), .bus_bias_mid_o(bmid),
      .bus_bias_gnd_o(bgnd), .bus_float_o(bfl), .vcc_uv_i(vuv), .vcc_low90_i(v90),
      .vbat_uv_i(buv), .dev_off_i(doff), .dev_overtemp_i(dot), .sleep_by_uv_i(suv),
      .regulator_inhibit_out_o(regulator_inhibit_out), .xcvr_active_o(act));
   ctmw_ctl_model ctl_u (.clk_i(clk_i), .go_i(go), .byte_i(byt), .hold_low_i(hold),
      .rxd_i(rxd), .txd_o(txd), .busy_o(busy), .bad_o(bad));

   always #25 clk_i = ~clk_i;

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until ready is sampled high at a rising edge, data taken there
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk_i);
      pen <= 1;
      k = 0;
      do begin @(posedge clk_i); k++; end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin err_count++; tally_and_finish(); end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      pen  <= 0;
   endtask

   // polls the status register with a bounded count
   task automatic wait_st(input logic [2:0] s);
      for (int i = 0; i < 200; i++) begin
         apb(0, `CTMW_STAT_OFS, 32'h0);
         if (rd[2:0] === s) break;
      end
      chk("state", {29'h0, s}, rd & 32'h7);
   endtask

   task automatic wake(input int d1, input int r, input int d2);
      @(posedge clk_i);
      wdom <= 1; repeat (d1) @(posedge clk_i);
      wdom <= 0; repeat (r) @(posedge clk_i);
      wdom <= 1; repeat (d2) @(posedge clk_i);
      wdom <= 0; repeat (8) @(posedge clk_i);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1;
      apb(0, `CTMW_CTRL_OFS, 32'h0); chk("ctrl reset", 32'h40, rd);
      apb(0, 12'h00c, 32'h0); chk("unmapped err", 1, er); chk("unmapped data", 0, rd);
      wait_st(`CTMW_ST_OFFLINE);
      apb(1, `CTMW_CTRL_OFS, 32'h140);
      wake(DOM + 2, REC + 2 + WTO, DOM + 2);
      apb(0, `CTMW_EVT_OFS, 32'h0); chk("late pattern", 0, rd);
      repeat (WTO) @(posedge clk_i); // stale phases must time out first
      wait_st(`CTMW_ST_OFFLINE);
      apb(1, `CTMW_CTRL_OFS, 32'h110);
      repeat (3) @(negedge clk_i);
      chk("inhibit sleep", 0, regulator_inhibit_out); chk("rxd idle", 1, rxd);
      wake(DOM + 2, REC + 2, DOM + 2);
      apb(0, `CTMW_EVT_OFS, 32'h0); chk("wake flag", 1, rd);
      @(negedge clk_i); chk("rxd wake", 0, rxd); chk("inhibit", 1, regulator_inhibit_out);
      apb(0, `CTMW_CTRL_OFS, 32'h0); chk("standby", 32'h4, rd[6:4]);
      apb(1, `CTMW_EVT_OFS, 32'h1); apb(0, `CTMW_EVT_OFS, 32'h0); chk("clear", 0, rd);
      $display("done wake tests");
      apb(1, `CTMW_CTRL_OFS, 32'h171);
      wait_st(`CTMW_ST_ACTIVE);
      @(negedge clk_i); chk("active flag", 1, act);
      // corner bytes first, then random ones echoed over the bus
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         @(posedge clk_i);
         byt <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
         go  <= 1;
         @(posedge clk_i);
         go <= 0;
         k = 0;
         do begin @(negedge clk_i); k++; end while (busy !== 1'b0 && k < 200);
         if (k >= 200) begin err_count++; tally_and_finish(); end
      end
      chk("echo errors", 0, bad);
      apb(1, `CTMW_CTRL_OFS, 32'h173);
      wait_st(`CTMW_ST_LISTEN);
      @(negedge clk_i); chk("listen tx", 0, txen); chk("listen bias", 1, bmid);
      @(posedge clk_i);
      hold <= 1;
      apb(1, `CTMW_CTRL_OFS, 32'h171);
      repeat (10) @(posedge clk_i);
      apb(0, `CTMW_STAT_OFS, 32'h0); chk("txd low", 32'h4, rd & 32'h7);
      hold <= 0;
      wait_st(`CTMW_ST_ACTIVE);
      $display("done active tests");
      vuv <= 1;
      v90 <= 1;
      repeat (8) @(negedge clk_i);
      chk("uv drop", 0, act);
      @(posedge clk_i);
      vuv <= 0;
      v90 <= 0;
      apb(1, `CTMW_CTRL_OFS, 32'h172);
      wait_st(`CTMW_ST_ACTIVE);
      vuv <= 1;
      repeat (8) @(negedge clk_i);
      chk("uv ignored", 1, act);
      @(posedge clk_i);
      suv <= 1;
      repeat (8) @(negedge clk_i);
      chk("forced sleep", 0, act);
      @(posedge clk_i);
      vuv <= 0;
      suv <= 0;
      apb(1, `CTMW_CTRL_OFS, 32'h170);
      wait_st(`CTMW_ST_OFFLINE);
      @(negedge clk_i); chk("gnd bias", 1, bgnd);
      @(posedge clk_i);
      doff <= 1;
      repeat (8) @(negedge clk_i);
      chk("float", 1, bfl);
      @(posedge clk_i);
      doff <= 0;
      wait_st(`CTMW_ST_OFFLINE);
      $display("done supply tests");
      tally_and_finish();
   end
endmodule // can_transceiver_mode_wake_bench
